/* hw/sfo_params.svh */
// Constants of the offset-programmable synchronous FIFO.
// Assumes inclusion by bare name from the package and the assertion checker.
`ifndef SFO_PARAMS_SVH
`define SFO_PARAMS_SVH

`define SFO_DATA_W        9
`define SFO_DEPTH         16384
`define SFO_OFS_REG_W     9
`define SFO_OFS_DEFAULT   9'h007
`define SFO_OFS_HI_RESET  9'h000
`define SFO_SEL_W         2
`define SFO_BUF_DEPTH     8

`endif

/* hw/sfo_pkg.sv */
// Types shared by the offset-programmable FIFO design.
// Assumes sfo_params.svh is on the include path.
`include "sfo_params.svh"

package sfo_pkg;

    typedef enum logic [1:0] {
        SFO_SEL_EMPTY_LO = 2'h0,
        SFO_SEL_EMPTY_HI = 2'h1,
        SFO_SEL_FULL_LO  = 2'h2,
        SFO_SEL_FULL_HI  = 2'h3
    } sfo_sel_t;

    typedef struct packed {
        logic [`SFO_OFS_REG_W-1:0] empty_offset_low;
        logic [`SFO_OFS_REG_W-1:0] empty_offset_high;
        logic [`SFO_OFS_REG_W-1:0] full_offset_low;
        logic [`SFO_OFS_REG_W-1:0] full_offset_high;
    } sfo_offsets_t;

    typedef struct packed {
        logic empty_n;
        logic full_n;
        logic almost_empty_n;
        logic almost_full_n;
    } sfo_flags_t;

endpackage : sfo_pkg

/* hw/sfo_top.sv */
// Synchronous nine-bit FIFO with programmable almost-empty/full flags.
// Assumes write and read sides share core_clk and drive enables from
// logic on that clock; reset_n is held low for at least one edge.

module sfo_buffer #(
    parameter int WIDTH = `SFO_DATA_W,
    parameter int DEPTH = `SFO_BUF_DEPTH,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic      [AW:0]      count
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_r];
    assign count     = count_r;

    // Storage array.
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // Pointers wrap at the configured depth.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
        end
    end

    // Word count rises on each push and falls on each pop.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : sfo_buffer

module sfo_top #(
    parameter int DEPTH = `SFO_DEPTH,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic                   core_clk,
    input  wire logic                   reset_n,
    input  wire logic                   primary_write_enable_n,
    input  wire logic                   second_write_enable_or_load,
    input  wire logic                   first_read_enable_n,
    input  wire logic                   second_read_enable_n,
    input  wire logic [`SFO_DATA_W-1:0] data_in,
    output logic      [`SFO_DATA_W-1:0] data_out,
    output logic                        empty_flag_n,
    output logic                        full_flag_n,
    output logic                        almost_empty_flag_n,
    output logic                        almost_full_flag_n,
    output logic                        load_mode
);

    logic                   load_mode_r;
    sfo_pkg::sfo_offsets_t  offsets_r;
    sfo_pkg::sfo_sel_t      sel_r;
    sfo_pkg::sfo_sel_t      sel_nxt;
    sfo_pkg::sfo_flags_t    flags_r;
    logic [`SFO_DATA_W-1:0] data_out_r;
    logic [`SFO_DATA_W-1:0] ofs_read_data;
    logic [`SFO_DATA_W-1:0] buf_data;
    logic [AW:0]            count;
    logic [AW:0]            count_nxt;
    logic [AW:0]            empty_ofs;
    logic [AW:0]            full_ofs;
    logic [2*`SFO_OFS_REG_W-1:0] empty_cat;
    logic [2*`SFO_OFS_REG_W-1:0] full_cat;
    logic                   offset_load_n;
    logic                   read_en;
    logic                   ofs_write;
    logic                   ofs_read;
    logic                   fifo_write;
    logic                   fifo_read;
    logic                   buf_in_ready;
    logic                   buf_out_valid;

    // Strap is sampled on clock edges while reset is held.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            load_mode_r <= !second_write_enable_or_load;
        end
    end

    assign offset_load_n = load_mode_r ? second_write_enable_or_load : 1'b1;
    assign read_en       = !first_read_enable_n && !second_read_enable_n;

    assign ofs_write = load_mode_r && !offset_load_n
                       && !primary_write_enable_n;
    assign ofs_read  = load_mode_r && !offset_load_n && read_en;

    // Write into storage, gated by the full flag.
    assign fifo_write = !primary_write_enable_n && flags_r.full_n
                        && (load_mode_r ? offset_load_n
                                        : second_write_enable_or_load);

    // Read from storage, gated by the empty flag.
    assign fifo_read = read_en && !ofs_read && flags_r.empty_n;

    sfo_buffer #(
        .WIDTH (`SFO_DATA_W),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_store (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .in_valid  (fifo_write),
        .in_ready  (buf_in_ready),
        .in_data   (data_in),
        .out_valid (buf_out_valid),
        .out_ready (fifo_read),
        .out_data  (buf_data),
        .count     (count)
    );

    // Next sequence position after a write or read access.
    always_comb begin
        sel_nxt = sel_r;
        if (ofs_write || ofs_read) begin
            case (sel_r)
                sfo_pkg::SFO_SEL_EMPTY_LO: sel_nxt = sfo_pkg::SFO_SEL_EMPTY_HI;
                sfo_pkg::SFO_SEL_EMPTY_HI: sel_nxt = sfo_pkg::SFO_SEL_FULL_LO;
                sfo_pkg::SFO_SEL_FULL_LO:  sel_nxt = sfo_pkg::SFO_SEL_FULL_HI;
                sfo_pkg::SFO_SEL_FULL_HI:  sel_nxt = sfo_pkg::SFO_SEL_EMPTY_LO;
                default:                   sel_nxt = sfo_pkg::SFO_SEL_EMPTY_LO;
            endcase
        end
    end

    // Sequence position survives load release.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_r <= sfo_pkg::SFO_SEL_EMPTY_LO;
        end else begin
            sel_r <= sel_nxt;
        end
    end

    // Offset registers, loaded from the data inputs.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            offsets_r.empty_offset_low  <= `SFO_OFS_DEFAULT;
            offsets_r.empty_offset_high <= `SFO_OFS_HI_RESET;
            offsets_r.full_offset_low   <= `SFO_OFS_DEFAULT;
            offsets_r.full_offset_high  <= `SFO_OFS_HI_RESET;
        end else if (ofs_write) begin
            case (sel_r)
                sfo_pkg::SFO_SEL_EMPTY_LO:
                    offsets_r.empty_offset_low  <= data_in;
                sfo_pkg::SFO_SEL_EMPTY_HI:
                    offsets_r.empty_offset_high <= data_in;
                sfo_pkg::SFO_SEL_FULL_LO:
                    offsets_r.full_offset_low   <= data_in;
                sfo_pkg::SFO_SEL_FULL_HI:
                    offsets_r.full_offset_high  <= data_in;
                default:
                    offsets_r.empty_offset_low  <= data_in;
            endcase
        end
    end

    // Readback selection.
    always_comb begin
        case (sel_r)
            sfo_pkg::SFO_SEL_EMPTY_LO: ofs_read_data = offsets_r.empty_offset_low;
            sfo_pkg::SFO_SEL_EMPTY_HI: ofs_read_data = offsets_r.empty_offset_high;
            sfo_pkg::SFO_SEL_FULL_LO:  ofs_read_data = offsets_r.full_offset_low;
            sfo_pkg::SFO_SEL_FULL_HI:  ofs_read_data = offsets_r.full_offset_high;
            default:                   ofs_read_data = offsets_r.empty_offset_low;
        endcase
    end

    // Output register holds its last word while empty unless an offset read reloads it.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_out_r <= '0;
        end else if (ofs_read) begin
            data_out_r <= ofs_read_data;
        end else if (fifo_read) begin
            data_out_r <= buf_data;
        end
    end

    // Combined offsets: low register supplies the low nine bits.
    assign empty_cat = {offsets_r.empty_offset_high,
                        offsets_r.empty_offset_low};
    assign full_cat  = {offsets_r.full_offset_high,
                        offsets_r.full_offset_low};
    assign empty_ofs = {1'b0, empty_cat[AW-1:0]};
    assign full_ofs  = {1'b0, full_cat[AW-1:0]};
    assign count_nxt = count + (AW+1)'(fifo_write && buf_in_ready)
                       - (AW+1)'(fifo_read && buf_out_valid);

    // Status flags, each through one flip-flop.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_r.empty_n        <= 1'b0;
            flags_r.full_n         <= 1'b1;
            flags_r.almost_empty_n <= 1'b0;
            flags_r.almost_full_n  <= 1'b1;
        end else begin
            flags_r.empty_n        <= (count_nxt != '0);
            flags_r.full_n         <= (count_nxt != (AW+1)'(DEPTH));
            flags_r.almost_empty_n <= (count_nxt > empty_ofs);
            flags_r.almost_full_n  <= (count_nxt
                                       < (AW+1)'(DEPTH) - full_ofs);
        end
    end

    assign data_out            = data_out_r;
    assign empty_flag_n        = flags_r.empty_n;
    assign full_flag_n         = flags_r.full_n;
    assign almost_empty_flag_n = flags_r.almost_empty_n;
    assign almost_full_flag_n  = flags_r.almost_full_n;
    assign load_mode           = load_mode_r;

endmodule : sfo_top

/* tb/sfo_top_asserts.sv */
// Concurrent checks on the ports of the offset-programmable FIFO.
// Assumes one clock domain and an asynchronous active-low reset.
`include "sfo_params.svh"

module sfo_top_asserts #(
    parameter int DEPTH = 32
) (
    input wire logic                   core_clk,
    input wire logic                   reset_n,
    input wire logic                   primary_write_enable_n,
    input wire logic                   second_write_enable_or_load,
    input wire logic                   first_read_enable_n,
    input wire logic [`SFO_DATA_W-1:0] data_out,
    input wire logic                   empty_flag_n,
    input wire logic                   full_flag_n,
    input wire logic                   almost_empty_flag_n,
    input wire logic                   almost_full_flag_n,
    input wire logic                   load_mode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_reset_flags: assert property ($rose(reset_n) |-> !empty_flag_n &&
        full_flag_n && !almost_empty_flag_n && almost_full_flag_n)
        else $error("flags wrong after reset");
    a_mode_fixed: assert property ($past(reset_n) |-> $stable(load_mode))
        else $error("mode changed outside reset");
    a_empty_hold: assert property (!empty_flag_n && primary_write_enable_n
        && second_write_enable_or_load |=> !empty_flag_n && $stable(data_out))
        else $error("empty fifo was read");
    a_full_hold: assert property (!full_flag_n && first_read_enable_n
        |=> !full_flag_n) else $error("full fifo was written");
    a_write_fills: assert property (!empty_flag_n && !primary_write_enable_n
        && second_write_enable_or_load |=> empty_flag_n)
        else $error("write left fifo empty");
    a_rise_needs_wr: assert property ($rose(empty_flag_n) |->
        !$past(primary_write_enable_n)) else $error("empty cleared without write");
    a_fall_needs_wr: assert property ($fell(full_flag_n) |->
        !$past(primary_write_enable_n)) else $error("full set without write");
    a_empty_almost: assert property (!empty_flag_n |-> !almost_empty_flag_n)
        else $error("almost empty high while empty");
    a_full_almost: assert property (!full_flag_n |-> !almost_full_flag_n)
        else $error("almost full high while full");
endmodule : sfo_top_asserts

bind sfo_top sfo_top_asserts #(.DEPTH(DEPTH)) u_chk (
    .core_clk(core_clk), .reset_n(reset_n),
    .primary_write_enable_n(primary_write_enable_n),
    .second_write_enable_or_load(second_write_enable_or_load),
    .first_read_enable_n(first_read_enable_n), .data_out(data_out),
    .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n),
    .almost_full_flag_n(almost_full_flag_n), .load_mode(load_mode));

/* tb/sfo_host.sv */
// Host write-side and read-side logic facing the FIFO.
// Assumes the bench calls op once per cycle after a falling edge.
module sfo_host (
    input wire logic       core_clk,
    output logic           pwe_n,
    output logic           ld,
    output logic           ren_n,
    output logic     [8:0] din
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pwe_n = 1'h1;
        ld = 1'h0;
        ren_n = 1'h1;
        din = 9'h000;
    end
    // One cycle of access; callers never set w and r with load low.
    task op(input logic w, input logic r, input logic l, input logic [8:0] d);
        pwe_n = !w;
        ren_n = !r;
        ld = l;
        din = w ? d : ~din;
        @(negedge core_clk);
    endtask : op
endmodule : sfo_host

/* tb/tb_top.sv */
// Self-checking bench for the offset-programmable FIFO.
// Assumes sfo_top with a reduced depth of 32 and the host model.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = 32;
    logic core_clk = 1'h0;
    logic reset_n = 1'h0;
    logic pwe_n, ld, ren_n, ef, ff, aef, aff, lm;
    logic [8:0] din, dout;
    int err_total = 0;
    int comparisons = 0;
    int cnt = 0;
    always #20 core_clk = ~core_clk;
    sfo_host host (.core_clk(core_clk), .pwe_n(pwe_n), .ld(ld),
        .ren_n(ren_n), .din(din));
    sfo_top #(.DEPTH(DEPTH)) dut (.core_clk(core_clk), .reset_n(reset_n),
        .primary_write_enable_n(pwe_n), .second_write_enable_or_load(ld),
        .first_read_enable_n(ren_n), .second_read_enable_n(ren_n),
        .data_in(din), .data_out(dout), .empty_flag_n(ef), .full_flag_n(ff),
        .almost_empty_flag_n(aef), .almost_full_flag_n(aff), .load_mode(lm));

    task end_of_test();
        if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task flags(input int n, input int m);
        chk("flags", 9'({cnt != 0, cnt != DEPTH, cnt > n, cnt < DEPTH - m}),
            {5'h00, ef, ff, aef, aff});
    endtask : flags
    task rst(input logic strap);
        reset_n = 1'h0;
        host.pwe_n = 1'h1;
        host.ren_n = 1'h1;
        host.ld = strap;
        repeat (8) @(negedge core_clk);
        reset_n = 1'h1;
        host.ld = 1'h1;
        cnt = 0;
        chk("load_mode", {8'h00, !strap}, {8'h00, lm});
        flags(7, 7);
    endtask : rst
    task rb(input logic [8:0] e [4]);
        for (int i = 0; i < 4; i++) begin
            host.op(1'h0, 1'h1, 1'h0, 9'h000);
            chk("offset", e[i], dout);
        end
    endtask : rb

    initial begin
        #1ms;
        err_total++;
        end_of_test();
    end
    initial begin
        @(negedge core_clk);
        rst(1'h0);
        rb('{9'h007, 9'h000, 9'h007, 9'h000});
        host.op(1'h1, 1'h0, 1'h0, 9'h003);
        host.op(1'h1, 1'h0, 1'h0, 9'h000);
        host.op(1'h0, 1'h0, 1'h1, 9'h000);
        host.op(1'h0, 1'h0, 1'h0, 9'h0aa);
        host.op(1'h1, 1'h0, 1'h0, 9'h01b);
        host.op(1'h1, 1'h0, 1'h0, 9'h000);
        rb('{9'h003, 9'h000, 9'h01b, 9'h000});
        for (int i = 0; i <= DEPTH; i++) begin
            host.op(1'h1, 1'h0, 1'h1, 9'(i));
            if (i < DEPTH) cnt++;
            flags(3, 27);
        end
        for (int i = 0; i <= DEPTH; i++) begin
            host.op(1'h0, 1'h1, 1'h1, 9'h000);
            if (i < DEPTH) cnt--;
            chk("data_out", 9'(i < DEPTH ? i : DEPTH - 1), dout);
            flags(3, 27);
        end
        rst(1'h1);
        host.op(1'h1, 1'h0, 1'h0, 9'h155);
        flags(7, 7);
        for (int i = 0; i < 9; i++) begin
            host.op(1'h1, 1'h0, 1'h1, 9'h100 + 9'(i));
            cnt++;
            flags(7, 7);
        end
        host.op(1'h0, 1'h1, 1'h1, 9'h000);
        chk("data_out", 9'h100, dout);
        rst(1'h0);
        rb('{9'h007, 9'h000, 9'h007, 9'h000});
        end_of_test();
    end
endmodule : tb_top
